// ---- design/dmtc_clkdiv.sv ----
/*
 Clock-enable divider: one-cycle pulse every div_sel cycles.
 Assumes div_sel is at least 1 and held stable between mode changes.
*/
`default_nettype none
module dmtc_clkdiv #(
    parameter int W = 7
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] div_sel,
    output logic              tick
);
    logic [W-1:0] cnt_r;
    logic         last;

    assign last = (cnt_r >= div_sel - W'(1));
    assign tick = last;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= last ? '0 : cnt_r + W'(1);
        end
    end
endmodule // dmtc_clkdiv
`default_nettype wire

// ---- design/dmtc_ctrl.sv ----
/*
 Direct-transfer power-mode controller. Tracks the running mode, routes
 each matching direct-transfer sleep (RL6..RL10) through sleep or watch mode; raises the transfer interrupt only if dt_irq_enable and not global_irq_mask.
 Assumes the CPU gives a one-cycle sleep_exec pulse and control bits are
 stable then; the CPU clock is gated by cpu_clk_en.
*/
// How it works
// (RL1) Medium-speed mode clocks the CPU at one eighth of high-speed rate.
// (RL2) Sleep with direct-transfer set moves among high, medium, sub without halting; here the CPU clock stops while passing through sleep or watch.
// (RL3) After a direct mode change completes, raise the direct-transfer interrupt.
// (RL4) Transfer interrupt masked: sleep with direct-transfer parks in sleep or watch.
// (RL5) Global mask set: park in sleep or watch; no interrupt releases it.
// (RL6) High with standby 0, low 0, medium 1: go medium via sleep.
// (RL7) Medium with standby 0, low 0, medium 0: go high via sleep.
// (RL8) High or medium with standby 1, low 1, watch clock 1: go sub via watch.
// (RL9) Sub with standby 1, low 0, medium 0, watch 1: watch, wait, high.
// (RL10) Sub with standby 1, low 0, medium 1, watch 1: watch, wait, medium.
// (RL11) Wait code 000..011 gives 8192..65536 states; top bit set gives 131072.
// (RL12) Reset gives high-speed mode and cleared control bits.
`default_nettype none
module dmtc_ctrl (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       sleep_exec,
    input  wire logic       direct_transfer_enable,
    input  wire logic       software_standby_select,
    input  wire logic       low_speed_select,
    input  wire logic       medium_speed_select,
    input  wire logic       watch_clock_select,
    input  wire logic [2:0] settling_wait_code,
    input  wire logic       dt_irq_enable,
    input  wire logic       global_irq_mask,
    input  wire logic       wake_irq,
    output logic [2:0]      mode,
    output logic            cpu_clk_en,
    output logic            dt_irq,
    output logic            osc_settling
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    dmtc_pkg::dmtc_mode_t   mode_r, mode_nxt;
    dmtc_pkg::dmtc_mode_t   dest_r, dest_nxt;
    logic                   pend_r, pend_nxt;
    logic                   lock_r, lock_nxt;
    logic                   irq_r, irq_nxt;
    logic [17:0]            wait_r, wait_nxt;
    logic                   running;
    logic                   dt_go;
    logic                   to_med, to_high, to_sub, sub_hi, sub_med;
    logic [17:0]            wait_len;
    logic [6:0]             div_sel;
    logic                   tick;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    assign running = (mode_r == dmtc_pkg::DMTC_HIGH) || (mode_r == dmtc_pkg::DMTC_MEDIUM)
                  || (mode_r == dmtc_pkg::DMTC_SUB);
    assign dt_go   = sleep_exec && running && direct_transfer_enable; // [RL2]
    assign to_med  = (mode_r == dmtc_pkg::DMTC_HIGH) && !software_standby_select
                  && !low_speed_select && medium_speed_select; // [RL6]
    assign to_high = (mode_r == dmtc_pkg::DMTC_MEDIUM) && !software_standby_select
                  && !low_speed_select && !medium_speed_select; // [RL7]
    assign to_sub  = ((mode_r == dmtc_pkg::DMTC_HIGH) || (mode_r == dmtc_pkg::DMTC_MEDIUM))
                  && software_standby_select && low_speed_select && watch_clock_select; // [RL8]
    assign sub_hi  = (mode_r == dmtc_pkg::DMTC_SUB) && software_standby_select
                  && !low_speed_select && !medium_speed_select && watch_clock_select; // [RL9]
    assign sub_med = (mode_r == dmtc_pkg::DMTC_SUB) && software_standby_select
                  && !low_speed_select && medium_speed_select && watch_clock_select; // [RL10]

    // Top code bit alone selects the longest wait
    assign wait_len = settling_wait_code[2]        ? dmtc_pkg::DMTC_WAIT_4 :
                      (settling_wait_code == 3'h3) ? dmtc_pkg::DMTC_WAIT_3 :
                      (settling_wait_code == 3'h2) ? dmtc_pkg::DMTC_WAIT_2 :
                      (settling_wait_code == 3'h1) ? dmtc_pkg::DMTC_WAIT_1 :
                                                     dmtc_pkg::DMTC_WAIT_0; // [RL11]

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        mode_nxt = mode_r;
        dest_nxt = dest_r;
        pend_nxt = pend_r;
        lock_nxt = lock_r;
        irq_nxt  = 1'b0;
        wait_nxt = wait_r;
        unique case (mode_r)
            dmtc_pkg::DMTC_HIGH, dmtc_pkg::DMTC_MEDIUM, dmtc_pkg::DMTC_SUB: begin
                if (dt_go && (to_med || to_high)) begin
                    mode_nxt = dmtc_pkg::DMTC_SLEEP;
                    dest_nxt = to_med ? dmtc_pkg::DMTC_MEDIUM : dmtc_pkg::DMTC_HIGH;
                    wait_nxt = 18'(dmtc_pkg::DMTC_SLEEP_CYCLES);
                end else if (dt_go && (to_sub || sub_hi || sub_med)) begin
                    mode_nxt = dmtc_pkg::DMTC_WATCH;
                    dest_nxt = to_sub ? dmtc_pkg::DMTC_SUB :
                               sub_med ? dmtc_pkg::DMTC_MEDIUM : dmtc_pkg::DMTC_HIGH;
                    // Waking into active mode needs the oscillator to settle
                    wait_nxt = to_sub ? 18'(dmtc_pkg::DMTC_SLEEP_CYCLES) : wait_len; // [RL9] [RL10]
                end
                if (mode_nxt != mode_r) begin
                    pend_nxt = dt_irq_enable && !global_irq_mask; // [RL4]
                    lock_nxt = global_irq_mask; // [RL5]
                end
            end
            dmtc_pkg::DMTC_SLEEP, dmtc_pkg::DMTC_WATCH: begin
                if (wait_r != '0) begin
                    wait_nxt = wait_r - 18'h00001;
                end else if (pend_r) begin
                    mode_nxt = dest_r;
                    pend_nxt = 1'b0;
                    irq_nxt  = 1'b1; // [RL3]
                end else if (wake_irq && !lock_r) begin
                    // Masked transfer: an ordinary wake-up finishes the move
                    mode_nxt = dest_r; // [RL4]
                end
            end
            default: mode_nxt = dmtc_pkg::DMTC_RESET_MODE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_r <= dmtc_pkg::DMTC_RESET_MODE; // [RL12]
            dest_r <= dmtc_pkg::DMTC_RESET_MODE;
            pend_r <= 1'b0;
            lock_r <= 1'b0;
            irq_r  <= 1'b0;
            wait_r <= '0;
        end else begin
            mode_r <= mode_nxt;
            dest_r <= dest_nxt;
            pend_r <= pend_nxt;
            lock_r <= lock_nxt;
            irq_r  <= irq_nxt;
            wait_r <= wait_nxt;
        end
    end

    // ----------------------------------------
    // CPU clock enable
    // ----------------------------------------
    assign div_sel = (mode_r == dmtc_pkg::DMTC_MEDIUM) ? 7'(dmtc_pkg::DMTC_MED_DIV) :
                     (mode_r == dmtc_pkg::DMTC_SUB)    ? 7'(dmtc_pkg::DMTC_SUB_DIV) : 7'h01; // [RL1]

    dmtc_clkdiv #(.W(7)) u_div (
        .clk     (clk),
        .rst     (rst),
        .div_sel (div_sel),
        .tick    (tick)
    );

    // Halted in sleep and watch; program continues only after them
    assign cpu_clk_en   = running && tick; // [RL1] [RL2]
    assign mode         = mode_r;
    assign dt_irq       = irq_r;
    assign osc_settling = (mode_r == dmtc_pkg::DMTC_WATCH) && (wait_r != '0);
endmodule // dmtc_ctrl
`default_nettype wire

// ---- design/dmtc_pkg.sv ----
/*
 Package for the direct-transfer power-mode controller: mode encodings,
 medium and sub clock divide ratios, settling-wait table and reset values.
 Assumes a single 100 MHz clock domain.
*/
`default_nettype none
package dmtc_pkg;
    // ----------------------------------------
    // Modes
    // ----------------------------------------
    typedef enum logic [2:0] {
        DMTC_HIGH,
        DMTC_MEDIUM,
        DMTC_SUB,
        DMTC_SLEEP,
        DMTC_WATCH
    } dmtc_mode_t;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int DMTC_MED_DIV      = 8;
    localparam int DMTC_SUB_DIV      = 64;
    localparam int DMTC_SLEEP_CYCLES = 2;
    localparam int DMTC_WAIT_W       = 18;
    localparam logic [17:0] DMTC_WAIT_0 = 18'h02000;
    localparam logic [17:0] DMTC_WAIT_1 = 18'h04000;
    localparam logic [17:0] DMTC_WAIT_2 = 18'h08000;
    localparam logic [17:0] DMTC_WAIT_3 = 18'h10000;
    localparam logic [17:0] DMTC_WAIT_4 = 18'h20000;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam dmtc_mode_t DMTC_RESET_MODE = DMTC_HIGH;
endpackage : dmtc_pkg
`default_nettype wire

// ---- tb/dmtc_cpu_model.sv ----
/* CPU model: sleep pulse with its control bits; assumes one request at a time. */
`default_nettype none
module dmtc_cpu_model (
    input  wire logic       clk,
    input  wire logic       issue,
    input  wire logic [4:0] ctl,
    output logic            sleep_exec,
    output logic [4:0]      ctl_q
);
    timeunit 1ns;
    timeprecision 1ps;
    // Bits move only with the pulse, so they are stable when taken
    always_ff @(posedge clk) begin
        sleep_exec <= issue;
        if (issue) ctl_q <= ctl;
    end
endmodule // dmtc_cpu_model
`default_nettype wire

// ---- tb/dmtc_ctrl_properties.sv ----
/* Port checker for dmtc_ctrl; assumes the bind below the module. */
`default_nettype none
module dmtc_ctrl_properties (
    input wire logic       clk, rst, sleep_exec, direct_transfer_enable, dt_irq_enable, global_irq_mask,
    input wire logic       software_standby_select, low_speed_select, medium_speed_select, watch_clock_select,
    input wire logic [2:0] mode,
    input wire logic       cpu_clk_en, dt_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic ok  = sleep_exec & direct_transfer_enable & dt_irq_enable & ~global_irq_mask;
    wire logic dt  = sleep_exec & direct_transfer_enable & ~software_standby_select & ~low_speed_select;
    wire logic sub = software_standby_select & low_speed_select & watch_clock_select;
    wire logic ms  = medium_speed_select;
    wire logic hi  = mode == 3'h0;
    wire logic md  = mode == 3'h1;
    wire logic sl  = mode == 3'h3;
    wire logic wt  = mode == 3'h4;
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    a_high_med: assert property (ok && dt && ms && hi |=> sl [*3] ##1 md && dt_irq) else $error("Bad hop");
    a_med_high: assert property (ok && dt && !ms && md |=> sl [*3] ##1 hi && dt_irq) else $error("Bad hop");
    a_into_sub: assert property (ok && sub && (hi || md) |=> wt [*3] ##1 mode == 3'h2) else $error("Bad dive");
    a_med_rate: assert property (md && cpu_clk_en |=> (!md || !cpu_clk_en) [*7] ##1 (!md || cpu_clk_en))
        else $error("Bad medium rate");
    a_park_halt: assert property (sl || wt |-> !cpu_clk_en) else $error("Clock while parked");
    a_irq_off: assert property (dt && !dt_irq_enable && !ms && md |=> (sl && !dt_irq) [*3]) else $error("Unmasked");
    a_mask_park: assert property (dt && global_irq_mask && ms && hi |=> (sl && !dt_irq) [*8]) else $error("Left");
    a_irq_cause: assert property (dt_irq |-> $past(sl) || $past(wt)) else $error("Stray irq");
endmodule // dmtc_ctrl_properties
bind dmtc_ctrl dmtc_ctrl_properties dmtc_ctrl_properties_inst (.*);
`default_nettype wire

// ---- tb/dmtc_ctrl_tb.sv ----
/* Bench for dmtc_ctrl fed by the CPU model; assumes the fixed wait table. */
`default_nettype none
module dmtc_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0, rst, issue, sx, ien, gm, wake, cen, irq, osc;
    logic [4:0] ctl, cq;
    logic [2:0] code, mode;
    int         num_errors = 0, tests_run = 0, n;
    dmtc_cpu_model dmtc_cpu_model_inst (.clk, .issue, .ctl, .sleep_exec(sx), .ctl_q(cq));
    dmtc_ctrl dmtc_ctrl_inst (.clk, .rst, .sleep_exec(sx), .direct_transfer_enable(cq[4]),
        .software_standby_select(cq[3]), .low_speed_select(cq[2]), .medium_speed_select(cq[1]),
        .watch_clock_select(cq[0]), .settling_wait_code(code), .dt_irq_enable(ien), .global_irq_mask(gm),
        .wake_irq(wake), .mode, .cpu_clk_en(cen), .dt_irq(irq), .osc_settling(osc));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic conclude;
        if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
        tests_run++;
        if (g !== e) num_errors++;
        if (g !== e) $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    endtask
    // Bounded wait; a miss ends the run
    task automatic reach(input logic [2:0] m, input int lim);
        for (n = 0; mode !== m && n <= lim; n++) @(posedge clk) #1;
        chk("mode", 18'(m), 18'(mode));
        if (mode !== m) conclude();
    endtask
    task automatic sleep_op(input logic [4:0] c);
        @(posedge clk) {issue, ctl} <= {1'b1, c};
        @(posedge clk) issue <= 1'b0;
    endtask
    task automatic t_go(input logic [4:0] c, input logic [2:0] mid, input logic [2:0] d, input int w);
        sleep_op(c);
        reach(mid, 4);
        chk("settling", 18'(mid == 3'h4), 18'(osc));
        reach(d, w + 8);
        chk("parked", 18'(w + 1), 18'(n));
        chk("irq", 18'h1, 18'(irq));
    endtask
    // Wake from a global-mask park would hide a stuck mode
    task automatic t_mask;
        @(posedge clk) ien <= 1'b0;
        sleep_op(5'h10);
        reach(3'h3, 4);
        @(posedge clk) wake <= 1'b1;
        reach(3'h0, 20000);
        chk("masked irq", 18'h0, 18'(irq));
        @(posedge clk) {wake, ien, gm} <= 3'h3;
        sleep_op(5'h12);
        reach(3'h3, 4);
        @(posedge clk) wake <= 1'b1;
        repeat (300) @(posedge clk);
        #1 chk("locked", 18'h3, 18'(mode));
    endtask
    initial begin
        {rst, issue, ien, gm, wake, ctl, code} = 13'h1400;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        #1 chk("reset mode", 18'h0, 18'(mode));
        t_go(5'h12, 3'h3, 3'h1, 2);
        n = 0;
        repeat (64) @(posedge clk) #1 n += int'(cen);
        chk("ticks", 18'h8, 18'(n));
        t_go(5'h10, 3'h3, 3'h0, 2);
        t_go(5'h1D, 3'h4, 3'h2, 2);
        t_go(5'h19, 3'h4, 3'h0, 8192);
        t_go(5'h12, 3'h3, 3'h1, 2);
        t_go(5'h1D, 3'h4, 3'h2, 2);
        @(posedge clk) code <= 3'h1;
        t_go(5'h1B, 3'h4, 3'h1, 16384);
        t_mask;
        conclude;
    end
endmodule // dmtc_ctrl_tb
`default_nettype wire
